// ### msa_core.sv
// Purpose: next micro address register with fan-in and AXI4-Lite view
// Assumes: TIME180_IN pulses once per minor cycle at the latch point
// Notes: register bit n, counted from the top, sits at vector index 15-n
// What this block does
// [R01] pick the 14-bit next address from several enabled sources
// [R02] with no source enabled, load current address plus one
// [R03] jump loads bits 4..15 only, bits 2 and 3 kept
// [R04] store op naming start register routes ALU data, not at E6/E7
// [R05] store ops copy the address register into the blockpoint hold register
// [R06] control store read takes B contents via ALU input
// [R07] new slice normally starts from the processor start register
// [R08] back-to-back with no other request takes blockpoint hold value
// [R09] panel start address loads bits 4..15 and zeroes bits 2 and 3, first 4096 words
// [R10] only panel lines 7 and 10..15 carry address, others load zero
// [R11] register is 16 bits: 14 address bits plus overflow and link flags
// [R12] panel breakpoint compares with flags forced zero unless displayed
// [R13] during reset and load flags show burst error and table loading
// [R14] bits 8..15 are the table address during table phases
// [R15] address updates at time 180 while latch enable is active
// [R16] panel control store access allows updates only at E0
// [R17] main memory access withholds the latch enable
// [R18] null slice and back-to-back E6/E7 withhold the latch enable
// [R19] load override clears the register to address zero
// [R20] source enables are exclusive; increment only when none active
`timescale 1ns/10ps
`default_nettype none
`include "msa_params.svh"
module msa_core (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic TIME180_IN,
   input wire logic [`MSA_PHASE_W-1:0] PHASE_IN,
   input wire logic JUMP_LOAD_EN_IN,
   input wire logic [`MSA_JUMP_W-1:0] JUMP_ADDR_IN,
   input wire logic STORE_FROM_A_OP_IN,
   input wire logic STORE_FROM_B_OP_IN,
   input wire logic XFIELD_START_REG_IN,
   input wire logic CS_READ_OP_IN,
   input wire logic [`MSA_ADDR_W-1:0] ALU_DATA_IN,
   input wire logic SLICE_START_LOAD_EN_IN,
   input wire logic [`MSA_ADDR_W-1:0] START_REG_DATA_IN,
   input wire logic BACK_TO_BACK_SLICES_IN,
   input wire logic OTHER_REQUEST_IN,
   input wire logic [`MSA_ADDR_W-1:0] BLOCKPOINT_HOLD_IN,
   input wire logic PANEL_START_EN_IN,
   input wire logic PANEL_ACCESS_HOLD_IN,
   input wire logic MAIN_MEMORY_BUSY_IN,
   input wire logic NULL_SLICE_IN,
   input wire logic CS_LOAD_IN,
   input wire logic LOAD_OVERRIDE_IN,
   input wire logic ARITH_EXCESS_FLAG_IN,
   input wire logic LINK_FLAG_IN,
   input wire logic RESET_LOAD_IN,
   input wire logic BURST_ERR_IN,
   input wire logic TABLE_LOADING_IN,
   input wire logic BREAKPOINT_IN,
   input wire logic TABLE_PHASE_IN,
   input wire logic AWVALID_IN,
   input wire logic [`MSA_AXI_AW-1:0] AWADDR_IN,
   input wire logic WVALID_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   input wire logic BREADY_IN,
   input wire logic ARVALID_IN,
   input wire logic [`MSA_AXI_AW-1:0] ARADDR_IN,
   input wire logic RREADY_IN,
   output logic AWREADY_OUT,
   output logic WREADY_OUT,
   output logic BVALID_OUT,
   output logic [1:0] BRESP_OUT,
   output logic ARREADY_OUT,
   output logic RVALID_OUT,
   output logic [31:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   output logic [`MSA_REG_W-1:0] NEXT_ADDR_OUT,
   output logic [`MSA_REG_W-1:0] BP_COMPARE_OUT,
   output logic [`MSA_TBL_W-1:0] TABLE_ADDR_OUT,
   output logic TABLE_ADDR_VALID_OUT,
   output logic BP_HOLD_LOAD_OUT,
   output logic [`MSA_ADDR_W-1:0] BP_HOLD_DATA_OUT,
   output logic SEL_CLASH_OUT
);
   msa_sel_if sel ();
   logic [`MSA_REG_W-1:0] addr_reg;
   logic [`MSA_REG_W-1:0] addr_next;
   logic [`MSA_JUMP_W-1:0] panel_reg;
   logic disp_sel_reg;
   logic late_phase;
   logic store_op;
   logic latch_en;
   logic clear_now;
   logic update;
   logic [`MSA_REG_W-1:0] bp_next;
   logic aw_have_reg;
   logic w_have_reg;
   logic [`MSA_AXI_AW-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [31:0] rd_next;
   logic [1:0] rresp_next;

   msa_fanin msa_fanin_inst (
      .sel(sel)
   );

   assign late_phase = (PHASE_IN == `MSA_PHASE_E6) || (PHASE_IN == `MSA_PHASE_E7);
   assign store_op = STORE_FROM_A_OP_IN || STORE_FROM_B_OP_IN;

   assign sel.cur_addr = addr_reg[`MSA_ADDR_W-1:0];
   assign sel.jump_en = JUMP_LOAD_EN_IN; // see [R03]
   assign sel.jump_addr = JUMP_ADDR_IN;
   assign sel.alu_en = (store_op && XFIELD_START_REG_IN && !late_phase)
      || CS_READ_OP_IN; // see [R04] see [R06]
   assign sel.alu_data = ALU_DATA_IN;
   // back-to-back with nobody waiting reuses the blockpoint value
   assign sel.hold_en = SLICE_START_LOAD_EN_IN && BACK_TO_BACK_SLICES_IN
      && !OTHER_REQUEST_IN; // see [R08]
   assign sel.start_en = SLICE_START_LOAD_EN_IN && !sel.hold_en; // see [R07]
   assign sel.start_data = START_REG_DATA_IN;
   assign sel.hold_data = BLOCKPOINT_HOLD_IN;
   assign sel.panel_en = PANEL_START_EN_IN; // see [R09]
   assign sel.panel_addr = panel_reg;

   // hold conditions gate the latch point; override only acts during a load
   assign latch_en = !(PANEL_ACCESS_HOLD_IN && (PHASE_IN != `MSA_PHASE_E0)) // see [R16]
      && !MAIN_MEMORY_BUSY_IN // see [R17]
      && !NULL_SLICE_IN && !(BACK_TO_BACK_SLICES_IN && late_phase); // see [R18]
   assign clear_now = CS_LOAD_IN && LOAD_OVERRIDE_IN; // see [R19]
   assign update = TIME180_IN && (latch_en || clear_now); // see [R15]

   always_comb begin
      addr_next[13:0] = clear_now ? `MSA_CLEAR_ADDR : sel.sel_addr; // see [R01] see [R19]
      if (RESET_LOAD_IN) begin
         addr_next[15:14] = {BURST_ERR_IN, TABLE_LOADING_IN}; // see [R13]
      end else begin
         addr_next[15:14] = {ARITH_EXCESS_FLAG_IN, LINK_FLAG_IN}; // see [R11]
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         addr_reg <= `MSA_REG_RESET;
      end else if (CE_IN && update) begin
         addr_reg <= addr_next; // see [R15]
      end
   end

   // the hold copy tracks the register value that the store op produced
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         BP_HOLD_LOAD_OUT <= 1'b0;
         BP_HOLD_DATA_OUT <= `MSA_CLEAR_ADDR;
      end else if (CE_IN) begin
         BP_HOLD_LOAD_OUT <= update && store_op; // see [R05]
         if (update && store_op) begin
            BP_HOLD_DATA_OUT <= addr_next[13:0]; // see [R05]
         end
      end
   end

   always_comb begin
      bp_next = addr_reg;
      if (BREAKPOINT_IN && !disp_sel_reg) begin
         bp_next = {2'b00, addr_reg[13:0]}; // see [R12]
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         NEXT_ADDR_OUT <= `MSA_REG_RESET;
         BP_COMPARE_OUT <= `MSA_REG_RESET;
         TABLE_ADDR_OUT <= '0;
         TABLE_ADDR_VALID_OUT <= 1'b0;
         SEL_CLASH_OUT <= 1'b0;
      end else if (CE_IN) begin
         NEXT_ADDR_OUT <= addr_reg; // see [R11]
         BP_COMPARE_OUT <= bp_next;
         TABLE_ADDR_OUT <= addr_reg[7:0]; // see [R14]
         TABLE_ADDR_VALID_OUT <= TABLE_PHASE_IN; // see [R14]
         SEL_CLASH_OUT <= sel.multi; // see [R20]
      end
   end

   // write channel: address and data taken in either order, one at a time
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         AWREADY_OUT <= 1'b0;
         WREADY_OUT <= 1'b0;
         BVALID_OUT <= 1'b0;
         BRESP_OUT <= `MSA_RESP_OKAY;
      end else if (CE_IN) begin
         AWREADY_OUT <= !aw_have_reg && !(AWVALID_IN && AWREADY_OUT) && !BVALID_OUT;
         WREADY_OUT <= !w_have_reg && !(WVALID_IN && WREADY_OUT) && !BVALID_OUT;
         if (AWVALID_IN && AWREADY_OUT) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= AWADDR_IN;
         end
         if (WVALID_IN && WREADY_OUT) begin
            w_have_reg <= 1'b1;
            w_data_reg <= WDATA_IN;
            w_strb_reg <= WSTRB_IN;
         end
         if (aw_have_reg && w_have_reg) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            BVALID_OUT <= 1'b1;
            if ((aw_addr_reg == `MSA_OFF_PANEL) || (aw_addr_reg == `MSA_OFF_CTRL)) begin
               BRESP_OUT <= `MSA_RESP_OKAY;
            end else if (aw_addr_reg == `MSA_OFF_ADDR || aw_addr_reg == `MSA_OFF_BPCMP) begin
               BRESP_OUT <= `MSA_RESP_OKAY;
            end else begin
               BRESP_OUT <= `MSA_RESP_SLVERR;
            end
         end else if (BVALID_OUT && BREADY_IN) begin
            BVALID_OUT <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         panel_reg <= '0;
         disp_sel_reg <= 1'b0;
      end else if (CE_IN && aw_have_reg && w_have_reg) begin
         if (aw_addr_reg == `MSA_OFF_PANEL) begin
            if (w_strb_reg[0]) begin
               panel_reg[7:0] <= w_data_reg[7:0] & 8'(`MSA_PANEL_LINES); // see [R10]
            end
            if (w_strb_reg[1]) begin
               panel_reg[11:8] <= w_data_reg[11:8] & 4'(`MSA_PANEL_LINES >> 8); // see [R10]
            end
         end else if (aw_addr_reg == `MSA_OFF_CTRL) begin
            if (w_strb_reg[0]) begin
               disp_sel_reg <= w_data_reg[`MSA_CTRL_DISP];
            end
         end
      end
   end

   always_comb begin
      rd_next = '0;
      rresp_next = `MSA_RESP_OKAY;
      if (ARADDR_IN == `MSA_OFF_ADDR) begin
         rd_next = {16'h0000, addr_reg};
      end else if (ARADDR_IN == `MSA_OFF_PANEL) begin
         rd_next = {20'h00000, panel_reg};
      end else if (ARADDR_IN == `MSA_OFF_CTRL) begin
         rd_next = {31'h00000000, disp_sel_reg};
      end else if (ARADDR_IN == `MSA_OFF_BPCMP) begin
         rd_next = {16'h0000, bp_next};
      end else begin
         rresp_next = `MSA_RESP_SLVERR;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ARREADY_OUT <= 1'b0;
         RVALID_OUT <= 1'b0;
         RDATA_OUT <= '0;
         RRESP_OUT <= `MSA_RESP_OKAY;
      end else if (CE_IN) begin
         ARREADY_OUT <= !RVALID_OUT && !(ARVALID_IN && ARREADY_OUT);
         if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RDATA_OUT <= rd_next;
            RRESP_OUT <= rresp_next;
         end else if (RVALID_OUT && RREADY_IN) begin
            RVALID_OUT <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   sequence latch_taken;
      CE_IN && update;
   endsequence

   incr_default_a: assert property (latch_taken and !clear_now && !sel.jump_en && !sel.alu_en
      && !sel.start_en && !sel.hold_en && !sel.panel_en
      |=> addr_reg[13:0] == $past(addr_reg[13:0]) + 14'h0001) // see [R02]
      else $error("increment not loaded");
   jump_keeps_a: assert property (latch_taken and !clear_now && sel.jump_en && !sel.alu_en
      && !sel.start_en && !sel.hold_en && !sel.panel_en
      |=> addr_reg[13:12] == $past(addr_reg[13:12]) && addr_reg[11:0] == $past(JUMP_ADDR_IN)) // see [R03]
      else $error("jump altered bits 2 and 3");
   alu_late_a: assert property (late_phase && !CS_READ_OP_IN |-> !sel.alu_en) // see [R04]
      else $error("alu data routed at E6 or E7");
   hold_copy_a: assert property (latch_taken and store_op |=> BP_HOLD_LOAD_OUT
      && BP_HOLD_DATA_OUT == addr_reg[13:0]) // see [R05]
      else $error("blockpoint hold copy missing");
   panel_zero_a: assert property (latch_taken and !clear_now && PANEL_START_EN_IN
      |=> addr_reg[13:12] == 2'b00 && (addr_reg[11:0] & ~`MSA_PANEL_LINES) == 12'h000) // see [R09] see [R10]
      else $error("panel load set unassigned bits");
   hold_busy_a: assert property (CE_IN && MAIN_MEMORY_BUSY_IN && !clear_now
      |=> $stable(addr_reg)) // see [R17]
      else $error("address moved during memory access");
   panel_e0_a: assert property (CE_IN && PANEL_ACCESS_HOLD_IN && PHASE_IN != `MSA_PHASE_E0
      && !clear_now |=> $stable(addr_reg)) // see [R16]
      else $error("panel access updated outside E0");
   null_b2b_a: assert property (CE_IN && !clear_now && (NULL_SLICE_IN
      || (BACK_TO_BACK_SLICES_IN && late_phase)) |=> $stable(addr_reg)) // see [R18]
      else $error("address moved while withheld");
   clear_load_a: assert property (CE_IN && TIME180_IN && clear_now
      |=> addr_reg[13:0] == `MSA_CLEAR_ADDR) // see [R19]
      else $error("load override did not clear");
   bp_mask_a: assert property (CE_IN && BREAKPOINT_IN && !disp_sel_reg
      |=> BP_COMPARE_OUT[15:14] == 2'b00 ##0 BP_COMPARE_OUT[13:0] == $past(addr_reg[13:0])) // see [R12]
      else $error("breakpoint flags not masked");
   start_sel_a: assert property (latch_taken and !clear_now && !PANEL_START_EN_IN // see [R07]
      && SLICE_START_LOAD_EN_IN && !(BACK_TO_BACK_SLICES_IN && !OTHER_REQUEST_IN)
      |=> addr_reg[13:0] == $past(START_REG_DATA_IN))
      else $error("slice start address not loaded");
   hold_sel_a: assert property (latch_taken and !clear_now && !PANEL_START_EN_IN // see [R08]
      && SLICE_START_LOAD_EN_IN && BACK_TO_BACK_SLICES_IN && !OTHER_REQUEST_IN
      |=> addr_reg[13:0] == $past(BLOCKPOINT_HOLD_IN))
      else $error("blockpoint hold address not loaded");
   alu_sel_a: assert property (latch_taken and !clear_now && !PANEL_START_EN_IN // see [R06]
      && !SLICE_START_LOAD_EN_IN && CS_READ_OP_IN |=> addr_reg[13:0] == $past(ALU_DATA_IN))
      else $error("alu data not loaded");
   status_flags_a: assert property (latch_taken |=> addr_reg[15:14] // see [R11] see [R13]
      == ($past(RESET_LOAD_IN) ? $past({BURST_ERR_IN, TABLE_LOADING_IN})
      : $past({ARITH_EXCESS_FLAG_IN, LINK_FLAG_IN})))
      else $error("status bits not loaded");
   table_addr_a: assert property (CE_IN |=> TABLE_ADDR_OUT == $past(addr_reg[7:0]) // see [R14]
      && TABLE_ADDR_VALID_OUT == $past(TABLE_PHASE_IN))
      else $error("table address not presented");
   clash_flag_a: assert property (CE_IN && JUMP_LOAD_EN_IN && CS_READ_OP_IN // see [R20]
      |=> SEL_CLASH_OUT)
      else $error("source clash not flagged");
   next_out_a: assert property (CE_IN |=> NEXT_ADDR_OUT == $past(addr_reg)) // see [R11]
      else $error("address output lags the register");
   bp_pass_a: assert property (CE_IN && !(BREAKPOINT_IN && !disp_sel_reg) // see [R12]
      |=> BP_COMPARE_OUT == $past(addr_reg))
      else $error("compare value not the full register");
   latch_point_a: assert property (CE_IN && !TIME180_IN |=> $stable(addr_reg)) // see [R15]
      else $error("address moved off the latch point");
endmodule
`default_nettype wire

// ### msa_core_tb.sv
// Purpose: self-checking bench of the next micro address select block
// Assumes: partner paces the latch pulse; the bench drives decode levels around it
// Notes: blockpoint hold input is the inverse of the shared data so sources differ
`timescale 1ns/10ps
`default_nettype none
`include "msa_params.svh"
module msa_core_tb;
   localparam logic [13:0] EN_JUMP = 14'h0001;
   localparam logic [13:0] EN_STORE_A = 14'h000a;
   localparam logic [13:0] EN_STORE_B = 14'h000c;
   localparam logic [13:0] EN_CSRD = 14'h0010;
   localparam logic [13:0] EN_SLICE = 14'h0020;
   localparam logic [13:0] EN_B2B = 14'h0040;
   localparam logic [13:0] EN_OTHER = 14'h0080;
   localparam logic [13:0] EN_PANEL = 14'h0100;
   localparam logic [13:0] EN_PHOLD = 14'h0200;
   localparam logic [13:0] EN_MEM = 14'h0400;
   localparam logic [13:0] EN_NULL = 14'h0800;
   localparam logic [13:0] EN_CLR = 14'h1000;
   localparam logic [13:0] EN_FRZ = 14'h2000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] en = EN_MEM;
   logic [13:0] d = 14'h0000;
   logic [6:0] f = 7'h00;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic t180, pre, awready, wready, bvalid, arready, rvalid, tbv, bpl, clash;
   logic [2:0] phase;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] nxt, bpc;
   logic [7:0] tba;
   logic [13:0] bpd, bpd_s;
   logic bpl_s, clash_s;
   int n_errors = 0, total_checks = 0, cyc = 0;

   msa_cs_partner msa_cs_partner_inst (.clk_in(clk), .rst_n_in(rst_n), .time180_out(t180),
      .pre_out(pre), .phase_out(phase));
   msa_core msa_core_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(!en[13]),
      .TIME180_IN(t180), .PHASE_IN(phase), .JUMP_LOAD_EN_IN(en[0]), .JUMP_ADDR_IN(d[11:0]),
      .STORE_FROM_A_OP_IN(en[1]), .STORE_FROM_B_OP_IN(en[2]), .XFIELD_START_REG_IN(en[3]),
      .CS_READ_OP_IN(en[4]), .ALU_DATA_IN(d), .SLICE_START_LOAD_EN_IN(en[5]),
      .START_REG_DATA_IN(d), .BACK_TO_BACK_SLICES_IN(en[6]), .OTHER_REQUEST_IN(en[7]),
      .BLOCKPOINT_HOLD_IN(~d), .PANEL_START_EN_IN(en[8]), .PANEL_ACCESS_HOLD_IN(en[9]),
      .MAIN_MEMORY_BUSY_IN(en[10]), .NULL_SLICE_IN(en[11]), .CS_LOAD_IN(en[12]),
      .LOAD_OVERRIDE_IN(en[12]), .ARITH_EXCESS_FLAG_IN(f[0]), .LINK_FLAG_IN(f[1]),
      .RESET_LOAD_IN(f[2]), .BURST_ERR_IN(f[3]), .TABLE_LOADING_IN(f[4]),
      .BREAKPOINT_IN(f[5]), .TABLE_PHASE_IN(f[6]), .AWVALID_IN(awv), .AWADDR_IN(awaddr),
      .WVALID_IN(wv), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .BREADY_IN(bready),
      .ARVALID_IN(arv), .ARADDR_IN(araddr), .RREADY_IN(rready), .AWREADY_OUT(awready),
      .WREADY_OUT(wready), .BVALID_OUT(bvalid), .BRESP_OUT(bresp), .ARREADY_OUT(arready),
      .RVALID_OUT(rvalid), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .NEXT_ADDR_OUT(nxt),
      .BP_COMPARE_OUT(bpc), .TABLE_ADDR_OUT(tba), .TABLE_ADDR_VALID_OUT(tbv),
      .BP_HOLD_LOAD_OUT(bpl), .BP_HOLD_DATA_OUT(bpd), .SEL_CLASH_OUT(clash));

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic final_report();
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   // enables are live only around the one latch pulse of the wanted phase;
   // between steps memory busy holds the address, so expectations do not drift
   task automatic step(input logic [2:0] ph, input logic [13:0] e, input logic [13:0] dv,
         input logic [15:0] x);
      do begin
         @(posedge clk);
         #1;
      end while (!(pre === 1'b1 && phase === ph));
      @(posedge clk);
      en <= e;
      d <= dv;
      @(posedge clk);
      en <= EN_MEM;
      #1;
      clash_s = clash;
      bpl_s = bpl;
      bpd_s = bpd;
      @(posedge clk);
      @(posedge clk);
      #1;
      chk("next address", nxt, x);
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat, input logic [1:0] resp);
      @(posedge clk);
      awaddr <= a;
      wdata <= dat;
      wstrb <= 4'hf;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awv <= 1'b0;
         if (wready === 1'b1) wv <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("write response", bresp, resp);
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] dat, input logic [1:0] resp);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arv <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("read data", rdata, dat);
      chk("read response", rresp, resp);
   endtask

   task automatic t_sources();
      chk("reset address", nxt, 16'h0000);
      step(3'h0, 14'h0000, 14'h0000, 16'h0001);
      step(3'h0, EN_STORE_A, 14'h2abc, 16'h2abc);
      chk("hold load", bpl_s, 1);
      chk("hold data", bpd_s, 14'h2abc);
      step(3'h0, EN_JUMP, 14'h1555, 16'h2555);
      axi_wr(`MSA_OFF_PANEL, 32'h0000_0fff, `MSA_RESP_OKAY);
      step(3'h0, EN_PANEL, 14'h3fff, 16'h013f);
      step(3'h6, EN_STORE_B, 14'h0f00, 16'h0140);
      step(3'h0, EN_CSRD, 14'h0123, 16'h0123);
      step(3'h0, EN_SLICE, 14'h0456, 16'h0456);
      step(3'h0, EN_SLICE | EN_B2B, 14'h0456, 16'h3ba9);
      step(3'h0, EN_SLICE | EN_B2B | EN_OTHER, 14'h0789, 16'h0789);
      step(3'h0, EN_JUMP | EN_CSRD, 14'h1aaa, 16'h1aaa);
      chk("clash", clash_s, 1);
   endtask

   task automatic t_holds();
      step(3'h3, EN_MEM, 14'h0000, 16'h1aaa);
      step(3'h2, EN_NULL, 14'h0000, 16'h1aaa);
      step(3'h6, EN_B2B, 14'h0000, 16'h1aaa);
      step(3'h7, EN_B2B, 14'h0000, 16'h1aaa);
      step(3'h5, EN_PHOLD, 14'h0000, 16'h1aaa);
      step(3'h0, EN_PHOLD, 14'h0000, 16'h1aab);
      step(3'h1, EN_FRZ, 14'h0000, 16'h1aab);
      step(3'h4, EN_MEM | EN_CLR, 14'h0000, 16'h0000);
   endtask

   task automatic t_status();
      @(posedge clk);
      f <= 7'h01;
      step(3'h0, 14'h0000, 14'h0000, 16'h8001);
      @(posedge clk);
      f <= 7'h16;
      step(3'h0, 14'h0000, 14'h0000, 16'h4002);
      @(posedge clk);
      f <= 7'h20;
      repeat (3) @(posedge clk);
      #1;
      chk("breakpoint compare", bpc, 16'h0002);
      axi_wr(`MSA_OFF_CTRL, 32'h0000_0001, `MSA_RESP_OKAY);
      repeat (3) @(posedge clk);
      #1;
      chk("breakpoint compare", bpc, 16'h4002);
      axi_rd(`MSA_OFF_CTRL, 32'h0000_0001, `MSA_RESP_OKAY);
      axi_wr(`MSA_OFF_CTRL, 32'h0000_0000, `MSA_RESP_OKAY);
      @(posedge clk);
      f <= 7'h40;
      repeat (3) @(posedge clk);
      #1;
      chk("table address", tba, 8'h02);
      chk("table valid", tbv, 1);
   endtask

   // read-only and unmapped places must leave the address register alone
   task automatic t_regs();
      axi_rd(`MSA_OFF_ADDR, 32'h0000_4002, `MSA_RESP_OKAY);
      axi_rd(`MSA_OFF_PANEL, 32'h0000_013f, `MSA_RESP_OKAY);
      axi_rd(4'h2, 32'h0000_0000, `MSA_RESP_SLVERR);
      axi_wr(`MSA_OFF_ADDR, 32'h0000_ffff, `MSA_RESP_OKAY);
      axi_wr(4'h2, 32'h0000_0001, `MSA_RESP_SLVERR);
      axi_rd(`MSA_OFF_ADDR, 32'h0000_4002, `MSA_RESP_OKAY);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_sources();
      t_holds();
      t_status();
      t_regs();
      final_report();
   end
endmodule
`default_nettype wire

// ### msa_cs_partner.sv
// Purpose: minor cycle timing as seen from the control store and decode side
// Assumes: four clocks per minor cycle, eight minor cycles E0..E7 per slice
// Notes: pre_out is high the cycle before the latch pulse so the bench can line up
`timescale 1ns/10ps
`default_nettype none
module msa_cs_partner (
   input wire logic clk_in,
   input wire logic rst_n_in,
   output logic time180_out,
   output logic pre_out,
   output var logic [2:0] phase_out
);
   logic [1:0] cnt_reg;
   // phase advances only after the latch pulse, so the pulse always sees a stable phase
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_reg <= 2'h0;
         phase_out <= 3'h0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         if (cnt_reg == 2'h3) begin
            phase_out <= phase_out + 3'h1;
         end
      end
   end
   assign time180_out = (cnt_reg == 2'h3);
   assign pre_out = (cnt_reg == 2'h2);
endmodule
`default_nettype wire

// ### msa_fanin.sv
// Purpose: selects the next 14-bit control store address
// Assumes: at most one source enable per minor cycle
// Notes: a fixed priority keeps the result defined if enables collide
`timescale 1ns/10ps
`default_nettype none
`include "msa_params.svh"
module msa_fanin (
   msa_sel_if.fanin sel
);
   logic [`MSA_ADDR_W-1:0] incr;
   logic [2:0] n_en;

   // address bits 2..3 sit at [13:12]; the jump and panel fields only cover [11:0]
   assign incr = sel.cur_addr + `MSA_ADDR_W'(1);
   assign n_en = 3'(sel.jump_en) + 3'(sel.alu_en) + 3'(sel.start_en)
      + 3'(sel.hold_en) + 3'(sel.panel_en);
   assign sel.multi = (n_en > 3'h1); // see [R20]

   always_comb begin
      sel.sel_addr = incr; // see [R02]
      sel.sel_src = msa_pkg::MSA_SRC_INC;
      if (sel.panel_en) begin
         // panel sequences live in the first 4096 words
         sel.sel_addr = {2'b00, sel.panel_addr}; // see [R09]
         sel.sel_src = msa_pkg::MSA_SRC_PANEL;
      end else if (sel.hold_en) begin
         sel.sel_addr = sel.hold_data; // see [R08]
         sel.sel_src = msa_pkg::MSA_SRC_HOLD;
      end else if (sel.start_en) begin
         sel.sel_addr = sel.start_data; // see [R07]
         sel.sel_src = msa_pkg::MSA_SRC_START;
      end else if (sel.alu_en) begin
         sel.sel_addr = sel.alu_data; // see [R04] see [R06]
         sel.sel_src = msa_pkg::MSA_SRC_ALU;
      end else if (sel.jump_en) begin
         sel.sel_addr = {sel.cur_addr[13:12], sel.jump_addr}; // see [R03]
         sel.sel_src = msa_pkg::MSA_SRC_JUMP;
      end
   end
endmodule
`default_nettype wire

// ### msa_params.svh
// Purpose: constants for the micro address select block
// Assumes: bit n of the 16-bit address word, counted from the top, is vector index 15-n
// Notes: offsets are AXI4-Lite byte addresses
`ifndef MSA_PARAMS_SVH
`define MSA_PARAMS_SVH

`define MSA_ADDR_W 14
`define MSA_REG_W 16
`define MSA_JUMP_W 12
`define MSA_TBL_W 8
`define MSA_PHASE_W 3
`define MSA_PHASE_E0 3'h0
`define MSA_PHASE_E6 3'h6
`define MSA_PHASE_E7 3'h7
`define MSA_CLEAR_ADDR 14'h0000
`define MSA_REG_RESET 16'h0000
`define MSA_PANEL_LINES 12'h13f
`define MSA_OFF_ADDR 4'h0
`define MSA_OFF_PANEL 4'h4
`define MSA_OFF_CTRL 4'h8
`define MSA_OFF_BPCMP 4'hc
`define MSA_CTRL_DISP 0
`define MSA_RESP_OKAY 2'h0
`define MSA_RESP_SLVERR 2'h2
`define MSA_AXI_AW 4

`endif

// ### msa_pkg.sv
// Purpose: shared types of the micro address select block
// Assumes: nothing
// Notes: source codes report which fan-in input was chosen
package msa_pkg;
   typedef enum logic [2:0] {
      MSA_SRC_INC,
      MSA_SRC_JUMP,
      MSA_SRC_ALU,
      MSA_SRC_START,
      MSA_SRC_HOLD,
      MSA_SRC_PANEL
   } msa_src_t;
endpackage

// ### msa_sel_if.sv
// Purpose: carries source enables and data between core and fan-in
// Assumes: all signals change only at the clock
// Notes: purely combinational bundle
`timescale 1ns/10ps
`default_nettype none
`include "msa_params.svh"
interface msa_sel_if;
   logic [`MSA_ADDR_W-1:0] cur_addr;
   logic jump_en;
   logic [`MSA_JUMP_W-1:0] jump_addr;
   logic alu_en;
   logic [`MSA_ADDR_W-1:0] alu_data;
   logic start_en;
   logic [`MSA_ADDR_W-1:0] start_data;
   logic hold_en;
   logic [`MSA_ADDR_W-1:0] hold_data;
   logic panel_en;
   logic [`MSA_JUMP_W-1:0] panel_addr;
   logic [`MSA_ADDR_W-1:0] sel_addr;
   msa_pkg::msa_src_t sel_src;
   logic multi;
   modport core (output cur_addr, jump_en, jump_addr, alu_en, alu_data, start_en,
      start_data, hold_en, hold_data, panel_en, panel_addr, input sel_addr, sel_src, multi);
   modport fanin (input cur_addr, jump_en, jump_addr, alu_en, alu_data, start_en,
      start_data, hold_en, hold_data, panel_en, panel_addr, output sel_addr, sel_src, multi);
endinterface
`default_nettype wire
